/* File: include/sfcfe_params.svh */
// constants of the serial flash command front end
`ifndef SFCFE_PARAMS_SVH
`define SFCFE_PARAMS_SVH
`define SFCFE_OP_NOP         8'h00
`define SFCFE_OP_RST_ARM     8'h66
`define SFCFE_OP_RST         8'h99
`define SFCFE_OP_ENTER_NIB   8'h38
`define SFCFE_OP_EXIT_NIB    8'hff
`define SFCFE_OP_READ        8'h03
`define SFCFE_OP_FAST_READ   8'h0b
`define SFCFE_OP_WR_PMAP     8'h42
`define SFCFE_OP_LOCK_PMAP   8'h8d
`define SFCFE_OP_PERM_LOCK   8'he8
`define SFCFE_OP_UNPROTECT   8'h98
`define SFCFE_OP_PROG_SEC    8'ha5
`define SFCFE_OP_LOCK_SEC    8'h85
`define SFCFE_OP_WAKE_ID     8'hab
`define SFCFE_OP_SECT_ERASE  8'h20
`define SFCFE_OP_BLK_ERASE   8'hd8
`define SFCFE_OP_SET_BURST   8'hc0
`define SFCFE_OP_QUAD_OUT_RD 8'h6b
`define SFCFE_OP_QUAD_IO_RD  8'heb
`define SFCFE_OP_QUAD_WRAP   8'hec
`define SFCFE_OP_QUAD_PROG   8'h32
`define SFCFE_CONT_NIBBLE    4'ha
`define SFCFE_LOCKED_BYTE    8'h00
`define SFCFE_WRAP_ADDR      24'h000000
`define SFCFE_ARRAY_TOP      24'h1fffff
`define SFCFE_ID_BYTE        8'h5a
`define SFCFE_SINGLE_LAST    3'h7
`define SFCFE_NIBBLE_LAST    3'h1
`define SFCFE_ADDR_BYTES     2'h3
`define SFCFE_SEC_ADDR_BYTES 2'h2
`define SFCFE_SINGLE_DUMMY   2'h1
`define SFCFE_NIB_DUMMY      2'h2
`define SFCFE_NBYTES_MAX     9'h1ff
`define SFCFE_STATUS_KEEP    8'h30
`define SFCFE_STATUS_BUSY    0
`define SFCFE_STATUS_PLOCK   4
`define SFCFE_STATUS_SLOCK   5
`define SFCFE_CFG_QPE        1
`define SFCFE_CFG_RST        8'h08
`define SFCFE_CFG_WR_MASK    8'h82
`define SFCFE_BURST_8B       2'h0
`define SFCFE_SECT_MASK      24'hfff000
`define SFCFE_BLK64_MASK     24'hff0000
`define SFCFE_BLK32_MASK     24'hff8000
`define SFCFE_BLK8_MASK      24'hffe000
`endif

/* File: include/sfcfe_pkg.sv */
// types of the serial flash command front end
package sfcfe_pkg;
`include "sfcfe_params.svh"

	// link-side frame phases
	typedef enum logic [2:0]
	{
		ST_OPCODE,
		ST_ADDR,
		ST_MODE,
		ST_DUMMY,
		ST_DIN,
		ST_DOUT,
		ST_IGNORE
	} sfcfe_state_t;

	// one decoded command frame
	typedef struct packed
	{
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [8:0]  nbytes;
		logic [7:0]  data0;
		logic        executed;
	} sfcfe_cmd_t;

endpackage : sfcfe_pkg

/* File: src/sfcfe_sync.sv */
// three-stage synchroniser that updates once stages two and three agree
`timescale 1ns/1ps
module sfcfe_sync
#(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output      logic [W-1:0] o_q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// plain shift chain; only s2 reads s1
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end
		else
		begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// per bit, accept a change once two stages agree
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			always_ff @(posedge i_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					o_q[gi] <= RST_VAL[gi];
				else if (s2_r[gi] == s3_r[gi])
					o_q[gi] <= s3_r[gi];
			end
		end
	endgenerate
endmodule : sfcfe_sync

/* File: src/sfcfe_top.sv */
// serial flash command front end: link framing, decode, modes, status
`timescale 1ns/1ps
`include "sfcfe_params.svh"
// Functional notes
// - opcode and every byte: eight clocks single-line, two clocks nibble mode
// - reset runs only if previous frame armed it; any other command disarms
// - no-operation only clears a pending reset arm
// - reset: single-line, burst 8, status keeps bits 4-5, quad enable cleared
// - reset during program or erase aborts that operation
// - plain read only in single-line mode, 24-bit address, no dummy
// - plain read streams bytes, pointer increments, wraps to start
// - enter-nibble opcode switches to nibble mode until exit, reset or power cycle
// - exit opcode returns to single-line, works in both modes
// - in continuous read, first exit only ends continuous mode
// - after power-up the device is in single-line mode
// - single-line fast read: 24-bit address then one dummy byte
// - nibble fast read: opcode, three address, mode byte, two dummy bytes
// - nibble fast read data on falling edges, address wraps to zero
// - fast read returns zero for read-locked bytes
// - mode byte upper nibble A: next frame starts with address
// - other mode byte: next frame starts with a normal opcode
// - sector erase uses address down to bit 12 only
// - block erase uses bits down to 16, 15 or 13 by block size
// - quad commands rejected unless quad pin enable is set
// - write protection map: opcode and 1 to 6 data bytes
// - lock map has no bytes; permanent lock map takes 1 to 6 data bytes
// - global unprotect carries no further bytes
// - security area program: two address bytes, data; lock has none
// - wake and read id: three address bytes then endless id stream
// - quad pin enable is configuration bit 1
module sfcfe_top
#(
	parameter logic [23:0] ARRAY_TOP = `SFCFE_ARRAY_TOP,
	parameter logic [7:0]  ID_BYTE   = `SFCFE_ID_BYTE  // arbitrary value
)
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_sck,
	input  wire logic                  i_cs_n,
	input  wire logic [3:0]            i_sio_i,
	output      logic [3:0]            o_sio_o,
	output      logic [3:0]            o_sio_oe,
	output      logic [23:0]           o_mem_addr,
	input  wire logic [7:0]            i_mem_data,
	input  wire logic                  i_mem_locked,
	input  wire logic [7:0]            i_status_set,
	input  wire logic [7:0]            i_status_clr,
	input  wire logic                  i_cfg_wr,
	input  wire logic [7:0]            i_cfg_wdata,
	output      logic [7:0]            o_status,
	output      logic [7:0]            o_config,
	output      logic [1:0]            o_burst_code,
	output      logic                  o_nibble_mode,
	output      logic                  o_cont_read,
	output      logic                  o_sw_reset,
	output      logic                  o_abort_write,
	output      logic                  o_cmd_valid,
	output      sfcfe_pkg::sfcfe_cmd_t o_cmd
);
	import sfcfe_pkg::*;

	logic         frame_rst_n;
	sfcfe_state_t state_r;
	logic [2:0]   cnt_r;
	logic [7:0]   sh_r;
	logic [7:0]   sh_nxt;
	logic         byte_done;
	logic [7:0]   op_r;
	logic [23:0]  addr_r;
	logic [1:0]   nleft_r;
	logic         hs_r;
	logic         nib_r;
	logic         cont_r;
	logic         arm_r;
	logic         op_ok;
	logic         qpe_l;
	sfcfe_cmd_t   rec_r;
	logic         rec_tag_r;
	logic [7:0]   out_byte;
	logic [2:0]   core_sync;
	logic         cs_prev_r;
	logic         tag_seen_r;
	logic         new_cmd;
	logic         rst_exec;
	logic [7:0]   status_r;
	logic [7:0]   cfg_r;
	logic [7:0]   set_mask;
	logic [7:0]   clr_mask;

	// frame logic is held clear whenever select is high
	assign frame_rst_n = i_rst_n & ~i_cs_n;
	assign o_mem_addr  = addr_r;

	// quad pin enable into the link domain
	sfcfe_sync #(.W(1), .RST_VAL(1'b0)) u_qpe_sync
	(
		.i_clk   (i_sck),
		.i_rst_n (i_rst_n),
		.i_d     (cfg_r[`SFCFE_CFG_QPE]),
		.o_q     (qpe_l)
	);

	// shift in one or four lines per clock
	always_comb
	begin
		sh_nxt    = nib_r ? {sh_r[3:0], i_sio_i} : {sh_r[6:0], i_sio_i[0]};
		byte_done = (cnt_r == (nib_r ? `SFCFE_NIBBLE_LAST : `SFCFE_SINGLE_LAST));
	end

	// opcode validity for the current mode
	always_comb
	begin
		case (sh_nxt)
			`SFCFE_OP_RST:        op_ok = arm_r;
			`SFCFE_OP_ENTER_NIB,
			`SFCFE_OP_READ:       op_ok = ~nib_r;
			`SFCFE_OP_QUAD_OUT_RD,
			`SFCFE_OP_QUAD_IO_RD,
			`SFCFE_OP_QUAD_WRAP,
			`SFCFE_OP_QUAD_PROG:  op_ok = ~nib_r & qpe_l;
			`SFCFE_OP_NOP,
			`SFCFE_OP_RST_ARM,
			`SFCFE_OP_EXIT_NIB,
			`SFCFE_OP_FAST_READ,
			`SFCFE_OP_WR_PMAP,
			`SFCFE_OP_LOCK_PMAP,
			`SFCFE_OP_PERM_LOCK,
			`SFCFE_OP_UNPROTECT,
			`SFCFE_OP_PROG_SEC,
			`SFCFE_OP_LOCK_SEC,
			`SFCFE_OP_WAKE_ID,
			`SFCFE_OP_SECT_ERASE,
			`SFCFE_OP_BLK_ERASE,
			`SFCFE_OP_SET_BURST:  op_ok = 1'b1;
			default:              op_ok = 1'b0;
		endcase
	end

	// bit counter and shift register
	always_ff @(posedge i_sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			cnt_r <= 3'h0;
			sh_r  <= 8'h00;
		end
		else
		begin
			cnt_r <= byte_done ? 3'h0 : cnt_r + 3'h1;
			sh_r  <= sh_nxt;
		end
	end

	// frame phase sequencer
	always_ff @(posedge i_sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			state_r <= ST_OPCODE;
			op_r    <= `SFCFE_OP_NOP;
			addr_r  <= `SFCFE_WRAP_ADDR;
			nleft_r <= 2'h0;
			hs_r    <= 1'b0;
		end
		else if (byte_done)
		begin
			case (state_r)
				ST_OPCODE:
				begin
					if (cont_r)
					begin
						// opcode-less frame: first byte is address
						op_r    <= `SFCFE_OP_FAST_READ;
						addr_r  <= {addr_r[15:0], sh_nxt};
						nleft_r <= `SFCFE_ADDR_BYTES - 2'h1;
						hs_r    <= 1'b1;
						state_r <= (sh_nxt == `SFCFE_OP_EXIT_NIB) ? ST_IGNORE : ST_ADDR;
					end
					else
					begin
						op_r    <= sh_nxt;
						nleft_r <= `SFCFE_ADDR_BYTES;
						hs_r    <= (sh_nxt == `SFCFE_OP_FAST_READ);
						state_r <= ST_IGNORE;
						if (op_ok)
						begin
							case (sh_nxt)
								`SFCFE_OP_READ,
								`SFCFE_OP_FAST_READ,
								`SFCFE_OP_WAKE_ID,
								`SFCFE_OP_SECT_ERASE,
								`SFCFE_OP_BLK_ERASE:  state_r <= ST_ADDR;
								`SFCFE_OP_PROG_SEC:
								begin
									nleft_r <= `SFCFE_SEC_ADDR_BYTES;
									state_r <= ST_ADDR;
								end
								`SFCFE_OP_WR_PMAP,
								`SFCFE_OP_PERM_LOCK,
								`SFCFE_OP_SET_BURST:  state_r <= ST_DIN;
								default:              state_r <= ST_IGNORE;
							endcase
						end
					end
				end
				ST_ADDR:
				begin
					addr_r  <= {addr_r[15:0], sh_nxt};
					nleft_r <= nleft_r - 2'h1;
					if (nleft_r == 2'h1)
					begin
						case (op_r)
							`SFCFE_OP_READ,
							`SFCFE_OP_WAKE_ID:    state_r <= ST_DOUT;
							`SFCFE_OP_FAST_READ:
							begin
								nleft_r <= nib_r ? `SFCFE_NIB_DUMMY : `SFCFE_SINGLE_DUMMY;
								state_r <= nib_r ? ST_MODE : ST_DUMMY;
							end
							`SFCFE_OP_PROG_SEC:   state_r <= ST_DIN;
							default:              state_r <= ST_IGNORE;
						endcase
					end
				end
				ST_MODE:  state_r <= ST_DUMMY;
				ST_DUMMY:
				begin
					nleft_r <= nleft_r - 2'h1;
					if (nleft_r == 2'h1)
						state_r <= ST_DOUT;
				end
				ST_DOUT:
				begin
					// next byte, wrapping past the top of the array
					if (addr_r == ARRAY_TOP)
						addr_r <= `SFCFE_WRAP_ADDR;
					else
						addr_r <= addr_r + 24'h1;
				end
				default:  state_r <= state_r;
			endcase
		end
	end

	// mode flags and command record, kept across frames
	always_ff @(posedge i_sck or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			nib_r     <= 1'b0;
			cont_r    <= 1'b0;
			arm_r     <= 1'b0;
			rec_r     <= '0;
			rec_tag_r <= 1'b0;
		end
		else if (byte_done)
		begin
			case (state_r)
				ST_OPCODE:
				begin
					if (cont_r)
					begin
						if (sh_nxt == `SFCFE_OP_EXIT_NIB)
							cont_r <= 1'b0;
					end
					else
					begin
						arm_r     <= (sh_nxt == `SFCFE_OP_RST_ARM);
						rec_tag_r <= ~rec_tag_r;
						rec_r     <= '{opcode: sh_nxt, addr: 24'h0, nbytes: 9'h0,
							data0: 8'h00, executed: op_ok};
						if (op_ok)
						begin
							case (sh_nxt)
								`SFCFE_OP_ENTER_NIB:  nib_r <= 1'b1;
								`SFCFE_OP_EXIT_NIB:   nib_r <= 1'b0;
								`SFCFE_OP_RST:
								begin
									nib_r  <= 1'b0;
									cont_r <= 1'b0;
								end
								default:              nib_r <= nib_r;
							endcase
						end
					end
				end
				ST_ADDR:  rec_r.addr <= {addr_r[15:0], sh_nxt};
				ST_MODE:  cont_r <= (sh_nxt[7:4] == `SFCFE_CONT_NIBBLE);
				ST_DIN:
				begin
					if (rec_r.nbytes == 9'h0)
						rec_r.data0 <= sh_nxt;
					if (rec_r.nbytes != `SFCFE_NBYTES_MAX)
						rec_r.nbytes <= rec_r.nbytes + 9'h1;
				end
				default:  arm_r <= arm_r;
			endcase
		end
	end

	// byte to send: id, masked locked data, or array data
	always_comb
	begin
		out_byte = i_mem_data;
		if (op_r == `SFCFE_OP_WAKE_ID)
			out_byte = ID_BYTE;
		else if (hs_r && i_mem_locked)
			out_byte = `SFCFE_LOCKED_BYTE;
	end

	// output lines change on the falling clock edge
	always_ff @(negedge i_sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			o_sio_o  <= 4'h0;
			o_sio_oe <= 4'h0;
		end
		else if (state_r == ST_DOUT)
		begin
			if (nib_r)
			begin
				o_sio_o  <= cnt_r[0] ? out_byte[3:0] : out_byte[7:4];
				o_sio_oe <= 4'hf;
			end
			else
			begin
				o_sio_o  <= {2'b00, out_byte[3'h7 - cnt_r], 1'b0};
				o_sio_oe <= 4'h2;
			end
		end
		else
		begin
			o_sio_o  <= 4'h0;
			o_sio_oe <= 4'h0;
		end
	end

	// select and mode levels into the core domain
	sfcfe_sync #(.W(3), .RST_VAL(3'b001)) u_core_sync
	(
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({cont_r, nib_r, i_cs_n}),
		.o_q     (core_sync)
	);

	// a finished frame carrying a fresh record
	assign new_cmd  = core_sync[0] & ~cs_prev_r & (rec_tag_r != tag_seen_r);
	assign rst_exec = new_cmd & rec_r.executed & (rec_r.opcode == `SFCFE_OP_RST);

	// frame end tracking
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cs_prev_r  <= 1'b1;
			tag_seen_r <= 1'b0;
		end
		else
		begin
			cs_prev_r <= core_sync[0];
			if (new_cmd)
				tag_seen_r <= rec_tag_r;
		end
	end

	// status set and clear; a set wins over a clear
	always_comb
	begin
		set_mask = i_status_set;
		if (new_cmd && rec_r.executed && rec_r.opcode == `SFCFE_OP_LOCK_PMAP)
			set_mask[`SFCFE_STATUS_PLOCK] = 1'b1;
		if (new_cmd && rec_r.executed && rec_r.opcode == `SFCFE_OP_LOCK_SEC)
			set_mask[`SFCFE_STATUS_SLOCK] = 1'b1;
		clr_mask = i_status_clr;
		if (rst_exec)
			clr_mask = clr_mask | ~`SFCFE_STATUS_KEEP;
	end

	// status register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			status_r <= 8'h00;
		else
			status_r <= (status_r & ~clr_mask) | set_mask;
	end

	// configuration register; reset command beats a write
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cfg_r <= `SFCFE_CFG_RST;
		else
		begin
			if (i_cfg_wr)
				cfg_r <= (cfg_r & ~`SFCFE_CFG_WR_MASK) | (i_cfg_wdata & `SFCFE_CFG_WR_MASK);
			if (rst_exec)
				cfg_r[`SFCFE_CFG_QPE] <= 1'b0;
		end
	end

	// erase address keeps only the bits that pick the sector or block
	function automatic logic [23:0] erase_addr(input logic [7:0] op, input logic [23:0] a);
		logic [23:0] m;
		logic        top;
		m   = 24'hffffff;
		top = (a[23:16] == ARRAY_TOP[23:16]);
		if (op == `SFCFE_OP_SECT_ERASE)
			m = `SFCFE_SECT_MASK;
		else if (op == `SFCFE_OP_BLK_ERASE)
		begin
			if (a[23:16] == 8'h00 || top)
				m = (a[15] ^ top) ? `SFCFE_BLK32_MASK : `SFCFE_BLK8_MASK;
			else
				m = `SFCFE_BLK64_MASK;
		end
		return a & m;
	endfunction : erase_addr

	// command reporting, reset and abort pulses, burst length
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_cmd_valid   <= 1'b0;
			o_cmd         <= '0;
			o_sw_reset    <= 1'b0;
			o_abort_write <= 1'b0;
			o_burst_code  <= `SFCFE_BURST_8B;
		end
		else
		begin
			o_cmd_valid   <= new_cmd;
			o_sw_reset    <= rst_exec;
			o_abort_write <= rst_exec & status_r[`SFCFE_STATUS_BUSY];
			if (new_cmd)
			begin
				o_cmd      <= rec_r;
				o_cmd.addr <= erase_addr(rec_r.opcode, rec_r.addr);
			end
			if (rst_exec)
				o_burst_code <= `SFCFE_BURST_8B;
			else if (new_cmd && rec_r.opcode == `SFCFE_OP_SET_BURST && rec_r.nbytes != 9'h0)
				o_burst_code <= rec_r.data0[1:0];
		end
	end

	// registered copies of state for the core side
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_status      <= 8'h00;
			o_config      <= `SFCFE_CFG_RST;
			o_nibble_mode <= 1'b0;
			o_cont_read   <= 1'b0;
		end
		else
		begin
			o_status      <= status_r;
			o_config      <= cfg_r;
			o_nibble_mode <= core_sync[1];
			o_cont_read   <= core_sync[2];
		end
	end
endmodule : sfcfe_top

/* File: tb/sfcfe_asserts.sv */
// port checker for the serial flash command front end
`timescale 1ns/1ps
module sfcfe_checker
(
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	input wire logic                  i_cs_n,
	input wire logic [7:0]            i_status_set,
	input wire logic [3:0]            o_sio_oe,
	input wire logic [7:0]            o_status,
	input wire logic [7:0]            o_config,
	input wire logic [1:0]            o_burst_code,
	input wire logic                  o_nibble_mode,
	input wire logic                  o_cont_read,
	input wire logic                  o_sw_reset,
	input wire logic                  o_abort_write,
	input wire logic                  o_cmd_valid,
	input wire sfcfe_pkg::sfcfe_cmd_t o_cmd
);
	import sfcfe_pkg::*;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// link outputs released outside frames, legal enable patterns only
	a_oe_idle: assert property (i_cs_n |-> o_sio_oe == 4'h0)
		else $error("data lines driven with select high");
	a_oe_width: assert property (o_sio_oe inside {4'h0, 4'h2, 4'hf})
		else $error("illegal output enable pattern");
	a_single_oe: assert property (o_sio_oe == 4'h2 |-> !o_nibble_mode)
		else $error("single-line drive while in nibble mode");
	// software reset side effects
	a_reset_status: assert property (o_sw_reset && i_status_set == 8'h00 |=>
		(o_status & 8'hcf) == 8'h00)
		else $error("status not cleared by reset");
	a_reset_cfg: assert property (o_sw_reset |=> !o_config[1] && o_burst_code == 2'h0)
		else $error("config or burst not reset");
	a_reset_rec: assert property (o_sw_reset |-> o_cmd_valid && o_cmd.opcode == 8'h99
		&& o_cmd.executed)
		else $error("reset pulse without executed reset record");
	a_abort_pair: assert property (o_abort_write |-> o_sw_reset)
		else $error("abort without reset");
	// command record shape, continuous read only in nibble mode
	a_report_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
		else $error("report pulse longer than one cycle");
	a_record_hold: assert property (!o_cmd_valid |-> $stable(o_cmd))
		else $error("record changed without report");
	a_sect_mask: assert property (o_cmd_valid && o_cmd.opcode == 8'h20 |->
		o_cmd.addr[11:0] == 12'h000)
		else $error("sector address not masked");
	a_blk_mask: assert property (o_cmd_valid && o_cmd.opcode == 8'hd8 |->
		o_cmd.addr[12:0] == 13'h0000)
		else $error("block address not masked");
	a_quad_gate: assert property (o_cmd_valid && o_cmd.opcode == 8'h6b && !o_config[1] |->
		!o_cmd.executed)
		else $error("quad command accepted without pin enable");
	a_cont_nib: assert property (o_cont_read |-> o_nibble_mode)
		else $error("continuous read outside nibble mode");
	// main scenarios reached
	c_reset: cover property (o_sw_reset && o_abort_write);
	c_cont: cover property ($rose(o_cont_read));
	c_nib_read: cover property (o_sio_oe == 4'hf);
endmodule : sfcfe_checker

bind sfcfe_top sfcfe_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
	.i_status_set(i_status_set), .o_sio_oe(o_sio_oe), .o_status(o_status),
	.o_config(o_config), .o_burst_code(o_burst_code), .o_nibble_mode(o_nibble_mode),
	.o_cont_read(o_cont_read), .o_sw_reset(o_sw_reset), .o_abort_write(o_abort_write),
	.o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd));

/* File: tb/sfcfe_bench.sv */
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
module sfcfe_bench;
	import sfcfe_pkg::*;
	logic i_clk, i_rst_n, sck, cs_n, cfg_wr, cmd_valid, sw_rst, abort;
	logic [3:0] host_sio, sio_o, sio_oe, sio_w;
	logic [23:0] mem_addr;
	logic [7:0] st_set, st_clr, cfg_wd, status, config_q, rxq[$];
	logic [1:0] burst;
	logic nib_mode, cont;
	sfcfe_cmd_t cmd, last_cmd;
	int err_total, tests_run, n_rst, n_abort, cyc;
	localparam logic [7:0] ID = 8'h96; // arbitrary identifier
	// wire level: device wins where it drives
	assign sio_w = (sio_oe & sio_o) | (~sio_oe & host_sio);
	sfcfe_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_sio(host_sio), .i_sio(sio_w));
	sfcfe_top #(.ID_BYTE(ID)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(sck),
		.i_cs_n(cs_n), .i_sio_i(sio_w), .o_sio_o(sio_o), .o_sio_oe(sio_oe),
		.o_mem_addr(mem_addr), .i_mem_data(mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c),
		.i_mem_locked(mem_addr[23:16] == 8'h1e), .i_status_set(st_set),
		.i_status_clr(st_clr), .i_cfg_wr(cfg_wr), .i_cfg_wdata(cfg_wd), .o_status(status),
		.o_config(config_q), .o_burst_code(burst), .o_nibble_mode(nib_mode),
		.o_cont_read(cont), .o_sw_reset(sw_rst), .o_abort_write(abort),
		.o_cmd_valid(cmd_valid), .o_cmd(cmd));
	always #5 i_clk = ~i_clk;
	// report capture and timeout
	always @(posedge i_clk)
	begin
		if (cmd_valid === 1'b1) last_cmd = cmd;
		if (sw_rst === 1'b1) n_rst++;
		if (abort === 1'b1) n_abort++;
		cyc++;
		if (cyc == 60000)
		begin
			err_total++;
			$display("MISMATCH %0t run timed out", $time);
			complete_run();
		end
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// read stream against the array model, zeros for locked bytes on fast reads
	task automatic chk_stream(input logic [23:0] a, input bit fast);
		foreach (rxq[k])
		begin
			chk(rxq[k], (fast && a[23:16] == 8'h1e) ? 8'h00 : a[7:0] ^ a[15:8] ^ 8'h3c, "data");
			a = (a == 24'h1fffff) ? 24'h000000 : a + 24'h1;
		end
	endtask : chk_stream
	task automatic frame(input bit nib, input logic [7:0] tx[$], input int nrx);
		u_host.xfer(nib, tx, nrx, rxq);
		repeat (20) @(negedge i_clk);
	endtask : frame
	task automatic done(input string name);
		$display("test %s done", name);
	endtask : done
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial
	begin
		{i_clk, i_rst_n, cfg_wr, st_set, st_clr, cfg_wd} = '0;
		{err_total, tests_run, n_rst, n_abort, cyc} = '0;
		repeat (16) @(negedge i_clk);
		i_rst_n = 1'b1;
		repeat (20) @(negedge i_clk);
		chk(config_q, 8'h08, "config");
		chk(nib_mode, 1'b0, "mode");
		chk(status, 8'h00, "status");
		done("reset");
		frame(0, {8'h6b}, 0);
		chk({last_cmd.opcode, last_cmd.executed}, 9'h0d6, "quad gate");
		frame(0, {8'h77}, 0);
		chk({last_cmd.opcode, last_cmd.executed}, 9'h0ee, "unknown");
		done("refuse");
		frame(0, {8'h03, 8'h1f, 8'hff, 8'hfe}, 3);
		chk_stream(24'h1ffffe, 0);
		frame(0, {8'h0b, 8'h1d, 8'hff, 8'hff, 8'h00}, 2);
		chk_stream(24'h1dffff, 1);
		frame(0, {8'hab, 8'h00, 8'h00, 8'h00}, 2);
		chk({rxq[0], rxq[1]}, {ID, ID}, "id");
		done("read");
		frame(0, {8'h20, 8'h12, 8'h34, 8'h56}, 0);
		chk(last_cmd.addr, 24'h123000, "sector");
		frame(0, {8'hd8, 8'h12, 8'h34, 8'h56}, 0);
		chk(last_cmd.addr, 24'h120000, "block");
		frame(0, {8'h42, 8'h11, 8'h22, 8'h33}, 0);
		chk({last_cmd.nbytes, last_cmd.data0}, {9'h003, 8'h11}, "map");
		frame(0, {8'h8d}, 0);
		chk(status[4], 1'b1, "lock");
		frame(0, {8'h98}, 0);
		chk({last_cmd.opcode, last_cmd.executed}, 9'h131, "unprotect");
		frame(0, {8'ha5, 8'h00, 8'h10, 8'h77}, 0);
		chk({last_cmd.addr, last_cmd.nbytes}, {24'h000010, 9'h001}, "sec");
		frame(0, {8'hc0, 8'h03}, 0);
		chk(burst, 2'h3, "burst");
		done("commands");
		@(negedge i_clk) {st_set, cfg_wr, cfg_wd} = {8'h01, 1'b1, 8'h82};
		@(negedge i_clk) {st_set, cfg_wr} = '0;
		repeat (3) @(negedge i_clk);
		chk(config_q, 8'h8a, "cfg write");
		frame(0, {8'h6b}, 0);
		chk({last_cmd.opcode, last_cmd.executed}, 9'h0d7, "quad ok");
		frame(0, {8'h66}, 0);
		frame(0, {8'h00}, 0);
		frame(0, {8'h99}, 0);
		chk(n_rst, 0, "disarmed");
		frame(0, {8'h66}, 0);
		frame(0, {8'h99}, 0);
		chk({n_rst[3:0], n_abort[3:0]}, 8'h11, "reset");
		chk({status, config_q, burst}, {8'h10, 8'h88, 2'h0}, "after reset");
		done("swreset");
		frame(0, {8'h38}, 0);
		chk(nib_mode, 1'b1, "nibble");
		frame(1, {8'h03, 8'h00, 8'h00, 8'h10}, 0);
		chk({last_cmd.opcode, last_cmd.executed}, 9'h006, "read nibble");
		frame(1, {8'h0b, 8'h1f, 8'hff, 8'hff, 8'ha5, 8'h00, 8'h00}, 2);
		chk_stream(24'h1fffff, 1);
		chk(cont, 1'b1, "cont");
		frame(1, {8'h1e, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, 1);
		chk_stream(24'h1e0010, 1);
		chk(cont, 1'b0, "cont end");
		frame(1, {8'h0b, 8'h00, 8'h00, 8'h20, 8'ha0, 8'h00, 8'h00}, 1);
		chk_stream(24'h000020, 1);
		frame(1, {8'hff}, 0);
		chk({cont, nib_mode}, 2'b01, "first exit");
		frame(1, {8'hff}, 0);
		chk(nib_mode, 1'b0, "second exit");
		frame(0, {8'h03, 8'h00, 8'h00, 8'h05}, 1);
		chk_stream(24'h000005, 0);
		done("nibble");
		complete_run();
	end
endmodule : sfcfe_bench

/* File: tb/sfcfe_host.sv */
// host controller model driving the serial link
`timescale 1ns/1ps
module sfcfe_host
(
	output logic            o_sck,
	output logic            o_cs_n,
	output logic [3:0]      o_sio,
	input  wire logic [3:0] i_sio
);
	localparam time HALF = 80ns;
	initial
	begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_sio = 4'h0;
	end
	// one frame: header bytes out, then read bytes in; clock idles low between frames
	task automatic xfer(input bit nib, input logic [7:0] tx[$], input int nrx,
		output logic [7:0] rx[$]);
		logic [7:0] b;
		rx = {};
		b = 8'h00;
		#3ns; // keeps link edges off the core clock's edges
		o_cs_n = 1'b0;
		#HALF;
		foreach (tx[k])
		begin
			for (int s = 0; s < (nib ? 2 : 8); s++)
			begin
				o_sio = nib ? tx[k][7-4*s -: 4] : {~o_sio[3:1], tx[k][7-s]};
				#HALF o_sck = 1'b1;
				#HALF o_sck = 1'b0;
			end
		end
		for (int n = 0; n < nrx; n++)
		begin
			for (int s = 0; s < (nib ? 2 : 8); s++)
			begin
				o_sio = ~o_sio; // undriven lines keep changing
				#HALF o_sck = 1'b1;
				b = nib ? {b[3:0], i_sio} : {b[6:0], i_sio[1]};
				#HALF o_sck = 1'b0;
			end
			rx.push_back(b);
		end
		#HALF o_cs_n = 1'b1;
		o_sio = ~o_sio;
		#(5*HALF);
	endtask : xfer
endmodule : sfcfe_host
